// [src/mcc_regs.sv]
// Purpose: Main clock controller registers, source switch and prescaler
// Assumes: sys_clk stands for the main clock; oscillator events are pulses
// Notes:   Peripheral clock is delivered as a one-cycle enable pulse, held high while the prescaler is off
`timescale 1ns/1ps
`default_nettype none

module mcc_regs #(
  parameter int AW = 7
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          nrst,
  // Avalon-MM slave
  input  wire logic [AW-1:0] address,
  input  wire logic          read,
  input  wire logic          write,
  input  wire logic [31:0]   writedata,
  output logic [31:0]        readdata,
  output logic               waitrequest,
  // Write protection from the processor
  input  wire logic          writeProtectKey,
  input  wire logic          instrDone,
  // Oscillator side
  input  wire logic [3:0]    srcStableIn,
  input  wire logic [3:0]    periphSrcRequest,
  input  wire logic          fastOscTick,
  input  wire logic          extInputStarted,
  // Fuses and factory values
  input  wire logic          frequencyChoiceFuse,
  input  wire logic          trimLockFuse,
  input  wire logic [5:0]    factoryFine16,
  input  wire logic [5:0]    factoryFine20,
  input  wire logic [3:0]    factoryTemp16,
  input  wire logic [3:0]    factoryTemp20,
  // System state
  input  wire logic          sleepActive,
  input  wire logic          periphUsesSysClk,
  // Clock outputs
  output logic [1:0]         mainSourceSelect,
  output logic               peripheralClockTick,
  output logic               sysClockPinOutEn,
  output logic               fastOscPowerOn,
  output logic               fastOscGateOpen,
  output logic               ulpKeepRunning,
  output logic [5:0]         fastOscFineTrim,
  output logic [3:0]         fastOscTempSlope
);

  // Divide ratio from a ratio code; reserved codes fall back to two
  function automatic logic [6:0] ratioOf(input logic [3:0] code);
    logic [6:0] r;
    r = 7'h02;
    unique case (code)
      4'h0: r = 7'h02;
      4'h1: r = 7'h04;
      4'h2: r = 7'h08;
      4'h3: r = 7'h10;
      4'h4: r = 7'h20;
      4'h5: r = 7'h40;
      4'h8: r = 7'h06;
      4'h9: r = 7'h0A;
      4'hA: r = 7'h0C;
      4'hB: r = 7'h18;
      4'hC: r = 7'h30;
      default: r = 7'h02;  // Undefined ratio, kept harmless
    endcase
    return r;
  endfunction

  mcc_regs_pkg::mcc_bus_t busState_reg;
  logic [7:0]  srcCtrl_reg;
  logic [7:0]  preCtrl_reg;
  logic        freeze_reg;
  logic        fastStandby_reg;
  logic        ulpStandby_reg;
  logic [5:0]  fine_reg;
  logic [3:0]  temp_reg;
  logic        trimLock_reg;
  logic        fuseLoaded_reg;
  logic [1:0]  activeSrc_reg;
  logic        switching_reg;
  logic [2:0]  protect_reg;
  logic [2:0]  gateCnt_reg;
  logic [6:0]  preCnt_reg;
  logic        perTick_reg;
  logic [31:0] readdata_reg;
  logic [7:0]  index;
  logic        wrTake;
  logic        protOk;
  logic [3:0]  requested;
  logic        trimWriteOk;
  logic [7:0]  stateByte;
  logic [7:0]  rdByte;
  logic [1:0]  wantedSrc;

  assign index     = 8'(address[AW-1:2]);
  assign wantedSrc = srcCtrl_reg[mcc_regs_pkg::SRC_LSB +: 2];

  // One wait cycle per access; answer on the second edge
  assign waitrequest = (read | write) & (busState_reg == mcc_regs_pkg::BUS_IDLE);
  assign wrTake      = write & (busState_reg == mcc_regs_pkg::BUS_ANSWER);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      busState_reg <= mcc_regs_pkg::BUS_IDLE;
    end else if (busState_reg == mcc_regs_pkg::BUS_ANSWER) begin
      busState_reg <= mcc_regs_pkg::BUS_IDLE;
    end else if (read | write) begin
      busState_reg <= mcc_regs_pkg::BUS_ANSWER;
    end
  end

  // Key opens a window of four retired instructions for one write
  assign protOk = (protect_reg != 3'h0);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      protect_reg <= 3'h0;
    end else if (writeProtectKey) begin
      protect_reg <= mcc_regs_pkg::PROTECT_INSTRS;
    end else if (wrTake && protOk) begin
      protect_reg <= 3'h0;  // One protected write per key
    end else if (instrDone && protOk) begin
      protect_reg <= protect_reg - 3'h1;
    end
  end

  // Main clock control; frozen once the lock is set
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      srcCtrl_reg <= mcc_regs_pkg::SRC_CTRL_RST;
      preCtrl_reg <= mcc_regs_pkg::PRE_CTRL_RST;
    end else if (wrTake && protOk && !freeze_reg) begin
      if (index == mcc_regs_pkg::IDX_SRC_CTRL) begin
        srcCtrl_reg <= writedata[7:0] & 8'h83;
      end
      if (index == mcc_regs_pkg::IDX_PRE_CTRL) begin
        preCtrl_reg <= writedata[7:0] & 8'h1F;
      end
    end
  end

  // Lock register; only reset clears it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      freeze_reg <= 1'b0;
    end else if (wrTake && protOk && !freeze_reg && index == mcc_regs_pkg::IDX_LOCK &&
                 writedata[mcc_regs_pkg::FREEZE_BIT]) begin
      freeze_reg <= 1'b1;
    end
  end

  // Oscillator run-in-standby controls
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fastStandby_reg <= 1'b0;
      ulpStandby_reg  <= 1'b0;
    end else if (wrTake && protOk) begin
      if (index == mcc_regs_pkg::IDX_FAST_CTRL) begin
        fastStandby_reg <= writedata[mcc_regs_pkg::STANDBY_BIT];
      end
      if (index == mcc_regs_pkg::IDX_SLOW_CTRL) begin
        ulpStandby_reg <= writedata[mcc_regs_pkg::STANDBY_BIT];
      end
    end
  end

  // Trim writes: fuse lock, and main-clock lock while fast osc is main
  assign trimWriteOk = wrTake && protOk && fuseLoaded_reg && !trimLock_reg &&
                       !(freeze_reg && activeSrc_reg == mcc_regs_pkg::SRC_FAST);

  // Fuses are caught on the first edge after reset release
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fuseLoaded_reg <= 1'b0;
      trimLock_reg   <= 1'b0;
      fine_reg       <= 6'h00;
      temp_reg       <= 4'h0;
    end else if (!fuseLoaded_reg) begin
      fuseLoaded_reg <= 1'b1;
      trimLock_reg   <= trimLockFuse;
      fine_reg       <= frequencyChoiceFuse ? factoryFine20 : factoryFine16;
      temp_reg       <= frequencyChoiceFuse ? factoryTemp20 : factoryTemp16;
    end else if (trimWriteOk) begin
      if (index == mcc_regs_pkg::IDX_FAST_FINE) begin
        fine_reg <= writedata[5:0];
      end
      if (index == mcc_regs_pkg::IDX_FAST_TEMP) begin
        temp_reg <= writedata[3:0];
      end
    end
  end

  // Source requests: running main, pending main, or a peripheral
  always_comb begin
    requested = periphSrcRequest;
    requested[activeSrc_reg] = 1'b1;
    requested[wantedSrc]     = 1'b1;
  end

  // Fast oscillator gate opens after four oscillator cycles
  // Standby keeps it powered, so the analog start-up is already done
  assign fastOscPowerOn = requested[mcc_regs_pkg::SRC_FAST] | fastStandby_reg;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      gateCnt_reg <= 3'h0;
    end else if (!requested[mcc_regs_pkg::SRC_FAST] ||
                 !srcStableIn[mcc_regs_pkg::SRC_FAST]) begin
      gateCnt_reg <= 3'h0;
    end else if (fastOscTick && gateCnt_reg != mcc_regs_pkg::GATE_OSC_CYCLES) begin
      gateCnt_reg <= gateCnt_reg + 3'h1;
    end
  end

  assign fastOscGateOpen = requested[mcc_regs_pkg::SRC_FAST] &&
                           gateCnt_reg == mcc_regs_pkg::GATE_OSC_CYCLES;

  // Switch only when the new source is stable; old one runs meanwhile
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      activeSrc_reg <= mcc_regs_pkg::SRC_FAST;
      switching_reg <= 1'b0;
    end else if (wantedSrc != activeSrc_reg) begin
      // Stable flags sit at bits 4 to 7 in source-code order
      if (stateByte[3'h4 + {1'b0, wantedSrc}] ||
          (wantedSrc == mcc_regs_pkg::SRC_EXT && extInputStarted)) begin
        activeSrc_reg <= wantedSrc;
        switching_reg <= 1'b0;
      end else begin
        switching_reg <= 1'b1;
      end
    end else begin
      switching_reg <= 1'b0;
    end
  end

  assign mainSourceSelect = activeSrc_reg;

  // Status byte; stable flags only while the source is requested, except the external started flag
  always_comb begin
    stateByte = 8'h00;
    stateByte[mcc_regs_pkg::EXT_STARTED_BIT] = extInputStarted;
    stateByte[mcc_regs_pkg::CRYSTAL_BIT] = srcStableIn[mcc_regs_pkg::SRC_CRYSTAL] &
                                           requested[mcc_regs_pkg::SRC_CRYSTAL];
    stateByte[mcc_regs_pkg::ULP_BIT] = srcStableIn[mcc_regs_pkg::SRC_ULP] &
                                       requested[mcc_regs_pkg::SRC_ULP];
    stateByte[mcc_regs_pkg::FAST_BIT] = fastOscGateOpen;
    stateByte[mcc_regs_pkg::SWITCH_BIT] = switching_reg;
  end

  // Prescaler; keeps counting when the ratio changes, so one short period can appear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      preCnt_reg  <= 7'h00;
      perTick_reg <= 1'b0;
    end else if (!preCtrl_reg[mcc_regs_pkg::PRE_ON_BIT]) begin
      preCnt_reg  <= 7'h00;
      perTick_reg <= 1'b1;
    end else if (preCnt_reg >= ratioOf(preCtrl_reg[mcc_regs_pkg::RATIO_LSB +: 4]) - 7'h01) begin
      preCnt_reg  <= 7'h00;
      perTick_reg <= 1'b1;
    end else begin
      preCnt_reg  <= preCnt_reg + 7'h01;
      perTick_reg <= 1'b0;
    end
  end

  assign peripheralClockTick = perTick_reg;

  // Clock-out pin gate; held off in sleep unless a peripheral needs it
  assign sysClockPinOutEn = srcCtrl_reg[mcc_regs_pkg::SYS_CLOCK_PIN_OUT_BIT] &
                            (!sleepActive | periphUsesSysClk);

  assign ulpKeepRunning   = ulpStandby_reg;
  assign fastOscFineTrim  = fine_reg;
  assign fastOscTempSlope = temp_reg;

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdByte = 8'h00;
    unique case (index)
      mcc_regs_pkg::IDX_SRC_CTRL:  rdByte = srcCtrl_reg;
      mcc_regs_pkg::IDX_PRE_CTRL:  rdByte = preCtrl_reg;
      mcc_regs_pkg::IDX_LOCK:      rdByte = 8'h00;  // Reads zero, writes only
      mcc_regs_pkg::IDX_STATE:     rdByte = stateByte;
      mcc_regs_pkg::IDX_FAST_CTRL: rdByte = {6'h00, fastStandby_reg, 1'b0};
      mcc_regs_pkg::IDX_FAST_FINE: rdByte = {2'h0, fine_reg};
      mcc_regs_pkg::IDX_FAST_TEMP: rdByte = {trimLock_reg, 3'h0, temp_reg};
      mcc_regs_pkg::IDX_SLOW_CTRL: rdByte = {6'h00, ulpStandby_reg, 1'b0};
      default:                     rdByte = 8'h00;
    endcase
  end

  // Read data captured in the wait cycle, stands at the answer edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      readdata_reg <= 32'h0000_0000;
    end else if (read && busState_reg == mcc_regs_pkg::BUS_IDLE) begin
      readdata_reg <= {24'h00_0000, rdByte};
    end
  end

  assign readdata = readdata_reg;

endmodule : mcc_regs

`default_nettype wire

// [inc/mcc_regs_pkg.sv]
// Purpose: Constants for the main clock controller register block
// Assumes: Avalon-MM slave, 8-bit registers, one per aligned 32-bit word
// Notes:   Byte address of a register is four times its index
package mcc_regs_pkg;

  // Register indices; byte address is index times four
  localparam logic [7:0] IDX_SRC_CTRL   = 8'h00;
  localparam logic [7:0] IDX_PRE_CTRL   = 8'h01;
  localparam logic [7:0] IDX_LOCK       = 8'h02;
  localparam logic [7:0] IDX_STATE      = 8'h03;
  localparam logic [7:0] IDX_FAST_CTRL  = 8'h10;
  localparam logic [7:0] IDX_FAST_FINE  = 8'h11;
  localparam logic [7:0] IDX_FAST_TEMP  = 8'h12;
  localparam logic [7:0] IDX_SLOW_CTRL  = 8'h18;

  // Field positions
  localparam int SYS_CLOCK_PIN_OUT_BIT      = 7;
  localparam int SRC_LSB         = 0;
  localparam int RATIO_LSB       = 1;
  localparam int PRE_ON_BIT      = 0;
  localparam int FREEZE_BIT      = 0;
  localparam int EXT_STARTED_BIT = 7;
  localparam int CRYSTAL_BIT     = 6;
  localparam int ULP_BIT         = 5;
  localparam int FAST_BIT        = 4;
  localparam int SWITCH_BIT      = 0;
  localparam int STANDBY_BIT     = 1;
  localparam int TRIM_LOCK_BIT   = 7;

  // Reset values
  localparam logic [7:0] SRC_CTRL_RST = 8'h00;
  localparam logic [7:0] PRE_CTRL_RST = 8'h11;
  localparam logic [7:0] RW_CTRL_RST  = 8'h00;

  // Counts
  localparam logic [2:0] GATE_OSC_CYCLES = 3'h4;
  localparam logic [2:0] PROTECT_INSTRS  = 3'h4;

  // Main clock sources
  localparam logic [1:0] SRC_FAST    = 2'h0;
  localparam logic [1:0] SRC_ULP     = 2'h1;
  localparam logic [1:0] SRC_CRYSTAL = 2'h2;
  localparam logic [1:0] SRC_EXT     = 2'h3;

  // Bus answer states
  typedef enum logic [0:0] {BUS_IDLE, BUS_ANSWER} mcc_bus_t;

endpackage : mcc_regs_pkg

// [tb/mcc_regs_props.sv]
// Purpose: Port checks for the clock controller registers
// Assumes: One clock domain; fuse levels held steady between resets
// Notes:   Bound to every mcc_regs instance
`timescale 1ns/1ps
`default_nettype none

module mcc_regs_props (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       nrst,
  // Bus
  input wire logic       read,
  input wire logic       write,
  input wire logic       waitrequest,
  // Sources and system
  input wire logic [3:0] srcStableIn,
  input wire logic       fastOscTick,
  input wire logic       extInputStarted,
  input wire logic       trimLockFuse,
  input wire logic       sleepActive,
  input wire logic       periphUsesSysClk,
  // Outputs
  input wire logic [1:0] mainSourceSelect,
  input wire logic       peripheralClockTick,
  input wire logic       sysClockPinOutEn,
  input wire logic       fastOscGateOpen,
  input wire logic [5:0] fastOscFineTrim,
  input wire logic [3:0] fastOscTempSlope
);
  logic [2:0] tickCnt;
  logic [3:0] readyQ;
  logic       settled;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Ticks while the gate is shut; an unstable source restarts the count
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tickCnt <= 3'h0;
    end else if (fastOscGateOpen || !srcStableIn[0]) begin
      tickCnt <= 3'h0;
    end else if (fastOscTick) begin
      tickCnt <= tickCnt + 3'h1;
    end
  end

  // Source readiness one edge back, indexed by source code
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      readyQ  <= 4'h0;
      settled <= 1'b0;
    end else begin
      readyQ  <= {extInputStarted, srcStableIn[2:1], fastOscGateOpen};
      settled <= 1'b1;
    end
  end

  property p_wait_once;
    $rose(read || write) |-> waitrequest ##1 !waitrequest;
  endproperty
  a_wait_once: assert property (p_wait_once) else $error("bus answer not after one wait");
  property p_pin_cause;
    $changed(sysClockPinOutEn) && $stable(sleepActive) && $stable(periphUsesSysClk)
      |-> $past(write && !waitrequest);
  endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("clock pin changed alone");
  property p_pin_sleep;
    sleepActive && !periphUsesSysClk |-> !sysClockPinOutEn;
  endproperty
  a_pin_sleep: assert property (p_pin_sleep) else $error("clock pin on in sleep");
  property p_switch_ready;
    $changed(mainSourceSelect) |-> readyQ[mainSourceSelect];
  endproperty
  a_switch_ready: assert property (p_switch_ready) else $error("switched to unready");
  property p_gate_four;
    $rose(fastOscGateOpen) |-> tickCnt == 3'h4;
  endproperty
  a_gate_four: assert property (p_gate_four) else $error("gate opened off count");
  property p_gate_drop;
    !srcStableIn[0] |=> !fastOscGateOpen;
  endproperty
  a_gate_drop: assert property (p_gate_drop) else $error("gate open on unstable");
  property p_trim_lock;
    settled && trimLockFuse |=> $stable(fastOscFineTrim) && $stable(fastOscTempSlope);
  endproperty
  a_trim_lock: assert property (p_trim_lock) else $error("trim moved while fused");
  property p_reset_tick;
    $rose(nrst) |-> !peripheralClockTick [*4] ##[1:3] peripheralClockTick;
  endproperty
  a_reset_tick: assert property (p_reset_tick) else $error("first tick off");
endmodule // mcc_regs_props

bind mcc_regs mcc_regs_props i_mcc_regs_props (
  .sys_clk, .nrst, .read, .write, .waitrequest, .srcStableIn, .fastOscTick,
  .extInputStarted, .trimLockFuse, .sleepActive, .periphUsesSysClk, .mainSourceSelect,
  .peripheralClockTick, .sysClockPinOutEn, .fastOscGateOpen, .fastOscFineTrim,
  .fastOscTempSlope
);
`default_nettype wire

// [tb/tb_mcc_regs.sv]
// Purpose: Self-checking bench for the clock controller registers
// Assumes: Fuse choice high selects the 20 MHz factory trims
// Notes:   Bus tasks wait for the answer instead of assuming a latency
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_mcc_regs;
  // Stimulus
  logic        sys_clk, nrst, read, write, writeProtectKey, instrDone, fastOscTick;
  logic        extInputStarted, frequencyChoiceFuse, trimLockFuse, sleepActive, periphUsesSysClk;
  logic [6:0]  address;
  logic [31:0] writedata;
  logic [3:0]  srcStableIn, periphSrcRequest;
  // Design answers
  logic [31:0] readdata;
  logic        waitrequest, peripheralClockTick, sysClockPinOutEn, fastOscPowerOn;
  logic        fastOscGateOpen, ulpKeepRunning;
  logic [1:0]  mainSourceSelect;
  logic [5:0]  fastOscFineTrim;
  logic [3:0]  fastOscTempSlope;
  // Bench state and tables
  int          errors, checked, n, i, k;
  logic [31:0] rd;
  logic [4:0]  ridx [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h10, 5'h11, 5'h12, 5'h18, 5'h05};
  logic [7:0]  rexp [9] = '{8'h00, 8'h11, 8'h00, 8'h00, 8'h00, 8'h2A, 8'h05, 8'h00, 8'h00};
  logic [7:0]  preB [13] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h09, 8'h0B, 8'h11, 8'h13, 8'h15,
                             8'h17, 8'h19, 8'h08, 8'h0A};
  int          preN [13] = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48, 1, 1};
  logic [1:0]  srcs [3] = '{2'h2, 2'h3, 2'h0};

  mcc_regs i_mcc_regs (
    .sys_clk, .nrst, .address, .read, .write, .writedata, .readdata, .waitrequest,
    .writeProtectKey, .instrDone, .srcStableIn, .periphSrcRequest, .fastOscTick,
    .extInputStarted, .frequencyChoiceFuse, .trimLockFuse, .factoryFine16(6'h15),
    .factoryFine20(6'h2A), .factoryTemp16(4'h3), .factoryTemp20(4'h5), .sleepActive,
    .periphUsesSysClk, .mainSourceSelect, .peripheralClockTick, .sysClockPinOutEn,
    .fastOscPowerOn, .fastOscGateOpen, .ulpKeepRunning, .fastOscFineTrim, .fastOscTempSlope
  );

  // Clock, and a fast oscillator tick every other cycle
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) fastOscTick <= nrst & ~fastOscTick;

  task automatic stop_test();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // One Avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] idx, input logic [7:0] wd);
    int j;
    @(posedge sys_clk);
    address <= {idx, 2'b00};
    read <= !w;
    write <= w;
    writedata <= {24'h0, wd};
    for (j = 0; j < 20; j++) begin
      @(posedge sys_clk);
      if (waitrequest === 1'b0) break;
    end
    if (j == 20) begin
      errors++;
      stop_test();
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rc(input logic [4:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    `CHK(rd, {24'h0, exp})
  endtask

  // Key pulse, then gap retired instructions, then the write
  task automatic pw(input logic [4:0] idx, input logic [7:0] wd, input int gap);
    @(posedge sys_clk);
    writeProtectKey <= 1'b1;
    repeat (gap) begin
      @(posedge sys_clk);
      writeProtectKey <= 1'b0;
      instrDone <= 1'b1;
    end
    @(posedge sys_clk);
    writeProtectKey <= 1'b0;
    instrDone <= 1'b0;
    bus(1'b1, idx, wd);
  endtask

  // Cycles between two peripheral ticks; bounded so a dead divider fails
  task automatic period(output int p);
    for (p = 0; p < 300 && peripheralClockTick !== 1'b1; p++) @(posedge sys_clk);
    p = 0;
    do begin
      @(posedge sys_clk);
      p++;
    end while (peripheralClockTick !== 1'b1 && p < 300);
  endtask

  task automatic waitsel(input logic [1:0] s);
    for (k = 0; k < 100 && mainSourceSelect !== s; k++) @(posedge sys_clk);
  endtask

  // Watchdog over the whole run
  initial begin
    repeat (60000) @(posedge sys_clk);
    errors++;
    stop_test();
  end

  initial begin
    {nrst, read, write, writeProtectKey, instrDone, extInputStarted} = 6'h00;
    {trimLockFuse, sleepActive, periphUsesSysClk} = 3'h0;
    frequencyChoiceFuse = 1'b1;
    address = 7'h00;
    writedata = 32'h0;
    srcStableIn = 4'hC;
    periphSrcRequest = 4'h0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    bus(1'b1, 5'h05, 8'hFF);
    for (i = 0; i < 9; i++) rc(ridx[i], rexp[i]);
    bus(1'b1, 5'h01, 8'h00);
    rc(5'h01, 8'h11);
    pw(5'h01, 8'h00, 4);
    rc(5'h01, 8'h11);
    // Every legal divide code, then bypass with two field values
    for (i = 0; i < 13; i++) begin
      pw(5'h01, preB[i], 3);
      rc(5'h01, preB[i]);
      period(n);
      period(n);
      `CHK(n, preN[i])
    end
    // Switch to a source that is not yet stable
    pw(5'h00, 8'h01, 0);
    rc(5'h03, 8'h01);
    `CHK(mainSourceSelect, mcc_regs_pkg::SRC_FAST)
    srcStableIn <= 4'hE;
    waitsel(mcc_regs_pkg::SRC_ULP);
    `CHK(mainSourceSelect, mcc_regs_pkg::SRC_ULP)
    rc(5'h03, 8'h20);
    `CHK(fastOscPowerOn, 1'b0)
    pw(5'h10, 8'h02, 0);
    // Written registers show only after the answer edge
    @(posedge sys_clk);
    `CHK(fastOscPowerOn, 1'b1)
    `CHK(fastOscGateOpen, 1'b0)
    pw(5'h18, 8'h02, 0);
    @(posedge sys_clk);
    `CHK(ulpKeepRunning, 1'b1)
    srcStableIn <= 4'hF;
    periphSrcRequest <= 4'h1;
    extInputStarted <= 1'b1;
    for (i = 0; i < 3; i++) begin
      pw(5'h00, {6'h00, srcs[i]}, 0);
      waitsel(srcs[i]);
      `CHK(mainSourceSelect, srcs[i])
    end
    bus(1'b0, 5'h03, 8'h00);
    `CHK(rd[7], 1'b1)
    // Clock pin in run and in sleep
    pw(5'h00, 8'h80, 0);
    rc(5'h00, 8'h80);
    `CHK(sysClockPinOutEn, 1'b1)
    sleepActive <= 1'b1;
    @(posedge sys_clk);
    `CHK(sysClockPinOutEn, 1'b0)
    periphUsesSysClk <= 1'b1;
    @(posedge sys_clk);
    `CHK(sysClockPinOutEn, 1'b1)
    sleepActive <= 1'b0;
    pw(5'h11, 8'h07, 0);
    @(posedge sys_clk);
    `CHK(fastOscFineTrim, 6'h07)
    // Freeze, then try to move control and trim
    pw(5'h02, 8'h01, 0);
    pw(5'h01, 8'h03, 0);
    rc(5'h01, 8'h0A);
    rc(5'h02, 8'h00);
    pw(5'h11, 8'h09, 0);
    rc(5'h11, 8'h07);
    // Hardware reset with the trim fuse set
    nrst <= 1'b0;
    trimLockFuse <= 1'b1;
    frequencyChoiceFuse <= 1'b0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rc(5'h12, 8'h83);
    `CHK(fastOscTempSlope, 4'h3)
    `CHK(fastOscFineTrim, 6'h15)
    pw(5'h11, 8'h01, 0);
    rc(5'h11, 8'h15);
    pw(5'h01, 8'h03, 0);
    rc(5'h01, 8'h03);
    stop_test();
  end
endmodule // tb_mcc_regs
`default_nettype wire
